// File: verilog/sdps_pkg.sv
// Purpose: Shared constants and types for the SDRAM power-up and self-refresh link
// Assumes: 100 MHz system clock, slower speed grade timing
// Notes:   Cycle counts are derived from the times below
package sdps_pkg;
	// ------------------------------------------------------------
	// Clock and times
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 10000;
	localparam int T_POWERUP_US = 200;
	localparam int T_RAS_PS = 42000;
	localparam int T_RC_PS = 63000;
	localparam int T_RP_PS = 21000;
	localparam int T_IS_PS = 1500;
	localparam int T_REFI_PS = 15600000;
	localparam int T_MRD_CYC = 2;
	localparam int T_CLK_STABLE_CYC = 4;
	// ------------------------------------------------------------
	// Cycle counts
	// ------------------------------------------------------------
	localparam logic [14:0] CYC_POWERUP = 15'(T_POWERUP_US * 1000000 / CLK_PERIOD_PS);
	localparam logic [14:0] CYC_RAS = 15'((T_RAS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [14:0] CYC_RC = 15'((T_RC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [14:0] CYC_RP = 15'((T_RP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [14:0] CYC_XSR =
		15'((T_IS_PS + T_RC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [14:0] CYC_MRD = 15'(T_MRD_CYC);
	localparam logic [14:0] CYC_CLK_STABLE = 15'(T_CLK_STABLE_CYC);
	localparam logic [10:0] CYC_REFI = 11'(T_REFI_PS / CLK_PERIOD_PS);
	// ------------------------------------------------------------
	// Counts, widths, fields
	// ------------------------------------------------------------
	localparam logic [12:0] INIT_REFRESHES = 13'h0002;
	localparam logic [12:0] BURST_REFRESHES = 13'h1000;
	localparam int ADDR_W = 12;
	localparam int BA_W = 2;
	localparam int ALL_BANKS_BIT = 10;
	localparam logic [11:0] MODE_WORD = 12'h030;
	// ------------------------------------------------------------
	// Command codes: {cs_n, ras_n, cas_n, we_n}
	// ------------------------------------------------------------
	localparam logic [3:0] CMD_MRS = 4'h0;
	localparam logic [3:0] CMD_REF = 4'h1;
	localparam logic [3:0] CMD_PRE = 4'h2;
	localparam logic [3:0] CMD_NOP = 4'h7;
	localparam logic [3:0] CMD_DESEL = 4'hf;
	// ------------------------------------------------------------
	// States
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		C_PWR, C_PRE, C_MRS, C_REF, C_WAIT, C_IDLE, C_BPRE,
		C_SRIN, C_SRHOLD, C_SRCLK, C_SREXIT, C_BPOST
	} sdps_ctrl_state_t;
	typedef enum logic [2:0] {D_POWER, D_INIT, D_IDLE, D_SRIN, D_SR, D_XSR} sdps_mem_state_t;
endpackage

// File: verilog/sdps_link_if.sv
// Purpose: Command pins between controller and memory
// Assumes: Both ends run on the system clock
// Notes:   clk_run high means the memory clock is toggling
`timescale 1ns/1ns
`default_nettype none
interface sdps_link_if;
	logic cke;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic dqm;
	logic clk_run;
	logic [11:0] addr;
	logic [1:0] ba;
	logic dq_oe;
	modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, dqm, clk_run, addr, ba, input dq_oe);
	modport mem (input cke, cs_n, ras_n, cas_n, we_n, dqm, clk_run, addr, ba, output dq_oe);
endinterface
`default_nettype wire

// File: verilog/sdps_mem_end.sv
// Purpose: Memory end: tracks initialization and self-refresh
// Assumes: Controller keeps its own sequencing duties
// Notes:   Data path is out of scope; dq stays released
`timescale 1ns/1ns
`default_nettype none
module sdps_mem_end (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	sdps_link_if.mem link,
	output logic mem_ready_out,
	output logic mem_sref_out,
	output logic [7:0] int_refresh_count_out
);
	import sdps_pkg::*;

	typedef struct packed {
		sdps_mem_state_t st;
		logic precharged;
		logic mrs_done;
		logic [1:0] refs;
		logic ready;
		logic sref;
		logic dq_oe;
		logic [10:0] refi;
		logic [7:0] int_refs;
		logic [14:0] xcnt;
	} sdps_mem_reg_t;

	sdps_mem_reg_t r;
	sdps_mem_reg_t n;
	logic [3:0] cmd;
	logic live;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		n = r;
		cmd = {link.cs_n, link.ras_n, link.cas_n, link.we_n};
		live = link.cke && link.clk_run && !link.cs_n;
		n.dq_oe = 1'b0;
		case (r.st)
			D_POWER: begin
				if (link.cke) begin
					n.st = D_INIT;
				end
			end
			D_INIT: begin
				if (live && cmd == CMD_PRE && link.addr[ALL_BANKS_BIT]) begin
					n.precharged = 1'b1;
				end
				if (live && r.precharged && cmd == CMD_MRS) begin
					n.mrs_done = 1'b1;
				end
				if (live && r.precharged && cmd == CMD_REF && r.refs != 2'h3) begin
					n.refs = r.refs + 2'h1;
				end
				if (r.mrs_done && r.refs >= 2'h2) begin
					n.st = D_IDLE;
					n.ready = 1'b1;
				end
			end
			D_IDLE: begin
				if (!link.cke && link.clk_run && {link.cs_n, link.ras_n, link.cas_n} == 3'h0) begin
					n.st = D_SRIN;
					n.sref = 1'b1;
					n.ready = 1'b0;
				end
			end
			D_SRIN: begin
				n.st = D_SR;
				n.refi = CYC_REFI;
			end
			D_SR: begin
				if (r.refi == 11'h000) begin
					n.refi = CYC_REFI;
					n.int_refs = r.int_refs + 8'h01;
				end else begin
					n.refi = r.refi - 11'h001;
				end
				if (link.cke) begin
					n.st = D_XSR;
					n.xcnt = CYC_XSR;
				end
			end
			D_XSR: begin
				if (r.xcnt == 15'h0000) begin
					n.st = D_IDLE;
					n.sref = 1'b0;
					n.ready = 1'b1;
				end else begin
					n.xcnt = r.xcnt - 15'h0001;
				end
			end
			default: begin
				n.st = D_POWER;
			end
		endcase
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			r <= '{st: D_POWER, refi: CYC_REFI, default: '0};
		end else begin
			r <= n;
		end
	end

	assign link.dq_oe = r.dq_oe;
	assign mem_ready_out = r.ready;
	assign mem_sref_out = r.sref;
	assign int_refresh_count_out = r.int_refs;
endmodule
`default_nettype wire

// File: verilog/sdps_ctrl_end.sv
// Purpose: Controller end: power-up sequence, periodic refresh, self-refresh
// Assumes: Memory clock gating is shown by clk_run
// Notes:   Waits carry one cycle of margin
//
// Function
// - Power-up: clock-enable low, mask high, no-operation.
// - Run clock 200 us before clock-enable high.
// - Mask held high; memory releases data pins.
// - Precharge all banks after clock-enable rises.
// - Load mode register during initialization.
// - At least two initialization auto-refreshes.
// - Refreshes may precede or follow mode load.
// - Entry: select, row, column low, enable low.
// - Memory ignores all but clock-enable after entry.
// - Memory refreshes itself while clock-enable low.
// - Stay in self-refresh at least row-active time.
// - Restart stable clock before raising clock-enable.
// - Exit starts with chip-select high.
// - Wait exit time before completing commands.
// - Burst refresh 4096 before entry, after exit.
// - Row-active time is 42 ns.
// - Exit time is setup plus row cycle.
// - Auto-refresh average interval at most 15.6 us.
`timescale 1ns/1ns
`default_nettype none
module sdps_ctrl_end #(
	parameter logic [14:0] POWERUP_CYC = sdps_pkg::CYC_POWERUP
) (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic sref_req_in,
	input wire logic burst_refresh_in,
	sdps_link_if.ctrl link,
	output logic init_done_out,
	output logic in_sref_out,
	output logic busy_out
);
	import sdps_pkg::*;

	typedef struct packed {
		sdps_ctrl_state_t st;
		sdps_ctrl_state_t ret;
		logic [14:0] cnt;
		logic [12:0] refs;
		logic [10:0] refi;
		logic cke;
		logic [3:0] cmd;
		logic dqm;
		logic clk_run;
		logic [11:0] addr;
		logic [1:0] ba;
		logic init_done;
		logic in_sref;
		logic busy;
	} sdps_ctrl_reg_t;

	sdps_ctrl_reg_t r;
	sdps_ctrl_reg_t n;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		n = r;
		n.cmd = CMD_NOP;
		n.addr = 12'h000;
		n.ba = 2'h0;
		if (r.cnt != 15'h0000) begin
			n.cnt = r.cnt - 15'h0001;
		end
		if (r.refi != 11'h000) begin
			n.refi = r.refi - 11'h001;
		end
		case (r.st)
			C_PWR: begin
				n.cke = 1'b0;
				n.dqm = 1'b1;
				if (r.cnt == 15'h0000) begin
					n.cke = 1'b1;
					n.st = C_PRE;
				end
			end
			C_PRE: begin
				n.cmd = CMD_PRE;
				n.addr[ALL_BANKS_BIT] = 1'b1;
				n.cnt = CYC_RP;
				n.ret = C_MRS;
				n.st = C_WAIT;
			end
			C_MRS: begin
				n.cmd = CMD_MRS;
				n.addr = MODE_WORD;
				n.cnt = CYC_MRD;
				n.refs = INIT_REFRESHES;
				n.ret = C_REF;
				n.st = C_WAIT;
			end
			C_REF: begin
				n.cmd = CMD_REF;
				n.refs = r.refs - 13'h0001;
				n.cnt = CYC_RC;
				n.ret = (r.refs == 13'h0001) ? C_IDLE : C_REF;
				n.refi = CYC_REFI;
				n.st = C_WAIT;
			end
			C_WAIT: begin
				if (r.cnt <= 15'h0001) begin
					n.st = r.ret;
				end
			end
			C_IDLE: begin
				n.init_done = 1'b1;
				n.dqm = 1'b0;
				n.busy = 1'b0;
				if (r.refi <= 11'h001) begin
					n.cmd = CMD_REF;
					n.refi = CYC_REFI;
					n.cnt = CYC_RC;
					n.ret = C_IDLE;
					n.st = C_WAIT;
					n.busy = 1'b1;
				end else if (sref_req_in) begin
					n.busy = 1'b1;
					if (burst_refresh_in) begin
						n.refs = BURST_REFRESHES;
						n.st = C_BPRE;
					end else begin
						n.st = C_SRIN;
					end
				end
			end
			C_BPRE: begin
				n.cmd = CMD_REF;
				n.refs = r.refs - 13'h0001;
				n.cnt = CYC_RC;
				n.ret = (r.refs == 13'h0001) ? C_SRIN : C_BPRE;
				n.st = C_WAIT;
			end
			C_SRIN: begin
				n.cmd = CMD_REF;
				n.cke = 1'b0;
				n.cnt = CYC_RAS;
				n.in_sref = 1'b1;
				n.st = C_SRHOLD;
			end
			C_SRHOLD: begin
				n.cke = 1'b0;
				n.clk_run = 1'b0;
				if (r.cnt == 15'h0000 && !sref_req_in) begin
					n.clk_run = 1'b1;
					n.cnt = CYC_CLK_STABLE;
					n.st = C_SRCLK;
				end
			end
			C_SRCLK: begin
				n.cmd = CMD_DESEL;
				if (r.cnt == 15'h0000) begin
					n.cke = 1'b1;
					n.cmd = CMD_DESEL;
					n.cnt = CYC_XSR;
					n.st = C_SREXIT;
				end
			end
			C_SREXIT: begin
				n.cmd = CMD_DESEL;
				if (r.cnt == 15'h0000) begin
					n.in_sref = 1'b0;
					n.refi = CYC_REFI;
					if (burst_refresh_in) begin
						n.refs = BURST_REFRESHES;
						n.st = C_BPOST;
					end else begin
						n.st = C_IDLE;
					end
				end
			end
			C_BPOST: begin
				n.cmd = CMD_REF;
				n.refs = r.refs - 13'h0001;
				n.cnt = CYC_RC;
				n.refi = CYC_REFI;
				n.ret = (r.refs == 13'h0001) ? C_IDLE : C_BPOST;
				n.st = C_WAIT;
			end
			default: begin
				n.st = C_PWR;
			end
		endcase
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			r <= '{st: C_PWR, ret: C_PWR, cnt: POWERUP_CYC, refi: CYC_REFI,
				cmd: CMD_NOP, dqm: 1'b1, clk_run: 1'b1, busy: 1'b1, default: '0};
		end else begin
			r <= n;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign link.cke = r.cke;
	assign link.cs_n = r.cmd[3];
	assign link.ras_n = r.cmd[2];
	assign link.cas_n = r.cmd[1];
	assign link.we_n = r.cmd[0];
	assign link.dqm = r.dqm;
	assign link.clk_run = r.clk_run;
	assign link.addr = r.addr;
	assign link.ba = r.ba;
	assign init_done_out = r.init_done;
	assign in_sref_out = r.in_sref;
	assign busy_out = r.busy;
endmodule
`default_nettype wire

// File: verif/sdps_link_checker.sv
// Purpose: Protocol checks on the command pins
// Assumes: Both ends on sys_clk_in
// Notes:   up marks that cke has been high once
`timescale 1ns/1ns
`default_nettype none
module sdps_link_checker #(
	parameter logic [14:0] POWERUP_CYC = sdps_pkg::CYC_POWERUP
) (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic dqm,
	input wire logic clk_run,
	input wire logic [11:0] addr,
	input wire logic [1:0] ba,
	input wire logic dq_oe
);
	import sdps_pkg::*;
	logic up;
	logic [15:0] cnt;
	wire logic [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			up <= 1'b0;
			cnt <= 16'h0000;
		end else begin
			up <= up | cke;
			if (cnt != 16'hffff) begin
				cnt <= cnt + 16'h0001;
			end
		end
	end
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	power_nop_a: assert property (!up |-> cmd == CMD_NOP && dqm)
		else $error("power-up not idle");
	power_wait_a: assert property ($rose(cke) && !up |-> cnt > {1'b0, POWERUP_CYC})
		else $error("cke early");
	pre_all_a: assert property ($rose(cke) && !up |=> cmd == CMD_PRE && addr[10])
		else $error("no precharge all");
	mask_high_a: assert property ($rose(cke) && !up |-> dqm [*8])
		else $error("mask low");
	mode_load_a: assert property (cmd == CMD_MRS && cke
		|-> addr == MODE_WORD ##3 cmd == CMD_REF)
		else $error("mode load");
	ref_gap_a: assert property (cmd == CMD_REF && cke && $past(cke)
		|=> (cmd == CMD_NOP || cmd == CMD_DESEL) [*7])
		else $error("refresh gap");
	sr_entry_a: assert property ($fell(cke) && up |-> cmd == CMD_REF)
		else $error("entry code");
	sr_stay_a: assert property ($fell(cke) && up |=> !cke [*5])
		else $error("short residency");
	clk_first_a: assert property ($rose(cke) && up |-> clk_run && $past(clk_run, 5))
		else $error("clock not stable");
	exit_desel_a: assert property ($rose(cke) && up |-> cmd == CMD_DESEL [*8])
		else $error("exit not deselect");
	dq_off_a: assert property (dqm |-> !dq_oe)
		else $error("data driven");
	init_c: cover property ($rose(cke) && !up);
	sr_in_c: cover property ($fell(cke) && up);
	sr_out_c: cover property ($rose(cke) && up);
	burst_c: cover property (cmd == CMD_REF && up ##8 cmd == CMD_REF);
endmodule
`default_nettype wire

// File: verif/sdram_powerup_selfrefresh_seq_tb.sv
// Purpose: Bench joining controller and memory ends
// Assumes: Short power-up wait
// Notes:   Inputs change on falling edge
`timescale 1ns/1ns
`default_nettype none
module sdram_powerup_selfrefresh_seq_tb;
	import sdps_pkg::*;
	localparam logic [14:0] PUP = 15'h0014;
	logic sys_clk_in, rst_n_in, sref_req_in, burst_refresh_in;
	logic init_done_out, in_sref_out, busy_out, mem_ready_out, mem_sref_out;
	logic [7:0] int_refresh_count_out;
	int failures = 0;
	int comparisons = 0;
	int cycles = 0;
	int n;
	sdps_link_if link ();
	sdps_ctrl_end #(.POWERUP_CYC(PUP)) sdps_ctrl_end_i (.sys_clk_in, .rst_n_in, .sref_req_in,
		.burst_refresh_in, .link(link.ctrl), .init_done_out, .in_sref_out, .busy_out);
	sdps_mem_end sdps_mem_end_i (.sys_clk_in, .rst_n_in, .link(link.mem), .mem_ready_out,
		.mem_sref_out, .int_refresh_count_out);
	sdps_link_checker #(.POWERUP_CYC(PUP)) sdps_link_checker_i (.sys_clk_in, .rst_n_in,
		.cke(link.cke), .cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n),
		.we_n(link.we_n), .dqm(link.dqm), .clk_run(link.clk_run), .addr(link.addr),
		.ba(link.ba), .dq_oe(link.dq_oe));
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic int gap(input logic b);
		return b ? 4096 * 8 : 0;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(negedge sys_clk_in);
	endtask
	task automatic stop_test;
		$display("failures %0d comparisons %0d", failures, comparisons);
		if (failures == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic sref_round(input logic b, input int hold);
		int r0;
		int d;
		n = 0;
		burst_refresh_in = b;
		sref_req_in = 1'b1;
		while (in_sref_out !== 1'b1) begin
			tick(1);
			n++;
		end
		chk(n >= gap(b) + 2 && n <= gap(b) + 40, 1);
		tick(2);
		chk(mem_sref_out, 1);
		chk(mem_ready_out, 0);
		r0 = int_refresh_count_out;
		tick(hold);
		sref_req_in = 1'b0;
		n = 0;
		while (in_sref_out === 1'b1 || busy_out === 1'b1) begin
			tick(1);
			n++;
		end
		chk(n >= 14 + gap(b), 1);
		d = (int_refresh_count_out - r0) & 255;
		chk(d * 1561 <= hold + 40 && (d + 1) * 1561 >= hold, 1);
		tick(2);
		chk(mem_ready_out, 1);
	endtask
	// ------------------------------------------------------------
	// Clock, timeout, sequence
	// ------------------------------------------------------------
	initial begin
		sys_clk_in = 1'b0;
		forever #5 sys_clk_in = ~sys_clk_in;
	end
	always @(posedge sys_clk_in) begin
		cycles++;
		if (cycles == 95000) begin
			failures++;
			stop_test();
		end
	end
	initial begin
		rst_n_in = 1'b0;
		sref_req_in = 1'b1;
		burst_refresh_in = 1'b0;
		void'($urandom(48256));
		tick(20);
		chk(link.cke, 0);
		chk(link.dqm, 1);
		rst_n_in = 1'b1;
		n = 0;
		while (init_done_out !== 1'b1) begin
			if (n == PUP + 4) begin
				sref_req_in = 1'b0;
			end
			tick(1);
			n++;
		end
		sref_req_in = 1'b0;
		chk(n, PUP + 25);
		chk(in_sref_out, 0);
		tick(2);
		chk(mem_ready_out, 1);
		n = 0;
		while (busy_out !== 1'b1) begin
			tick(1);
			n++;
		end
		chk(n + 10 <= T_REFI_PS / CLK_PERIOD_PS && n + 18 >= T_REFI_PS / CLK_PERIOD_PS, 1);
		sref_round(1'b0, 1);
		sref_round(1'b0, 3200);
		repeat (3) sref_round(1'b0, $urandom_range(400, 0));
		sref_round(1'b1, $urandom_range(40, 0));
		stop_test();
	end
endmodule
`default_nettype wire
